// *** rtl/port_ctl_pkg.sv ***
package port_ctl_pkg;

   // Operating modes, taken from the mode input.
   typedef enum logic [2:0]
   {
      MODE_NORMAL_SINGLE,
      MODE_SPECIAL_SINGLE,
      MODE_NORMAL_EXPANDED_NARROW,
      MODE_NORMAL_EXPANDED_WIDE,
      MODE_SPECIAL_EXPANDED_NARROW,
      MODE_SPECIAL_EXPANDED_WIDE,
      MODE_PERIPHERAL,
      MODE_SPARE
   } op_mode_e;

   // Register word indexes. The assignment register offset is 0x0A, not a
   // multiple of four, so every offset is an index and the byte address is four times it.
   localparam logic [7:0] PIN_ASSIGN_INDEX = 8'h0A;
   localparam logic [7:0] PULL_UP_INDEX    = 8'h0C;
   localparam logic [7:0] LOW_DRIVE_INDEX  = 8'h0D;
   localparam logic [7:0] STATUS_INDEX     = 8'h0E;

   // Bit positions inside the assignment register.
   localparam int NO_DATA_ENABLE_BIT  = 7;
   localparam int CLOCK_TEST_BIT      = 6;
   localparam int PIPE_STATUS_BIT     = 5;
   localparam int NO_EXT_ECLK_BIT     = 4;
   localparam int LOW_STROBE_BIT      = 3;
   localparam int READ_WRITE_BIT      = 2;
   localparam int CAL_REF_BIT         = 1;
   localparam int DATA_ENABLE_SEL_BIT = 0;

   // Bit positions inside the pull and drive registers.
   localparam int PORT_H_BIT = 6;
   localparam int PORT_G_BIT = 5;
   localparam int PORT_E_BIT = 4;
   localparam int PORT_B_BIT = 1;
   localparam int PORT_A_BIT = 0;

   // Reset values of the assignment register per mode, then pull and drive reset values and write masks.
   localparam logic [7:0] ASSIGN_RESET_NORMAL_EXP = 8'h00;
   localparam logic [7:0] ASSIGN_RESET_SPECIAL    = 8'h2C;
   localparam logic [7:0] ASSIGN_RESET_PERIPHERAL = 8'hD0;
   localparam logic [7:0] ASSIGN_RESET_NORMAL_SC  = 8'h90;
   localparam logic [7:0] PULL_UP_RESET           = 8'h00;
   localparam logic [7:0] LOW_DRIVE_RESET         = 8'h00;
   localparam logic [7:0] PULL_UP_MASK            = 8'h73;
   localparam logic [7:0] LOW_DRIVE_MASK          = 8'h73;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   // Signals from the core that the alternate pin functions carry.
   typedef struct packed
   {
      logic       eclk;
      logic       eclk_stretch_control;
      logic       data_bus_enable;
      logic       queue_status_1;
      logic       queue_status_0;
      logic       low_byte_strobe;
      logic       read_write;
      logic       clock_generator_test;
      logic       calibration_reference;
   } bus_signals_s;

   // Port E pin drive: output value and active-low output enable.
   typedef struct packed
   {
      logic [7:0] dout;
      logic [7:0] oe_n;
   } pin_drive_s;

endpackage : port_ctl_pkg

// *** rtl/bus_control_pin_mux.sv ***
// Overview of operation
// - Alternate function overrides the direction bit.
// - Normal single-chip reset sets only no-enable bits.
// - Normal expanded reset clears all assignment bits.
// - Special reset enables pipe, strobe, read/write.
// - Peripheral mode hides register; clock test on pin6.
// - Write-once normal; special ignores first write.
// - Clock test and no-eclk stricter; no-eclk writable on any write in special single-chip.
// - Pin 7 data enable, else calibration or I/O.
// - Clock test on pin 6; pipe status wins.
// - Pipe status on pins 6,5 in expanded modes.
// - Pin 4 E clock, stretch gates in single-chip.
// - E clock pin input only in peripheral mode.
// - Low strobe on pin 3 except normal narrow/single.
// - Narrow normal expanded drives pin 3 high.
// - Read/write on pin 2 outside single-chip.
// - Calibration enable writable on every write outside peripheral mode, drives pin 7.
// - Data enable select picks enable or inverted E.
// - Inverted E clock mirrors E clock.
// - Pull enables act only on input pins.
// - Ports A, B pulls off when bus.
// - Reduced drive per port, write-once normal.
// - Pull and drive registers hidden in peripheral.
//
// Decided for this implementation: register access over AHB-Lite.
module bus_control_pin_mux
(
   // AHB-Lite slave.
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   input  wire logic                       hsel,
   input  wire logic [31:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic [31:0]                hwdata,
   input  wire logic                       hready,
   output logic      [31:0]                hrdata,
   output logic                            hreadyout,
   output logic                            hresp,
   // Mode and core signals.
   input  wire port_ctl_pkg::op_mode_e     op_mode,
   input  wire port_ctl_pkg::bus_signals_s bus_in,
   // General-purpose port E settings.
   input  wire logic [7:0]                 gpio_dout,
   input  wire logic [7:0]                 bus_control_port_direction,
   input  wire logic [7:0]                 pin_in,
   // Pin drive and pad controls.
   output port_ctl_pkg::pin_drive_s        pin_out,
   output logic [7:0]                      pull_enable,
   output logic                            port_a_pull_active,
   output logic                            port_b_pull_active,
   output logic                            port_g_pull_active,
   output logic                            port_h_pull_active,
   output logic [4:0]                      low_drive,
   output logic                            low_byte_tag
);
   import port_ctl_pkg::*;

   function automatic logic mode_special(input op_mode_e m);
      return m == MODE_SPECIAL_SINGLE || m == MODE_SPECIAL_EXPANDED_NARROW || m == MODE_SPECIAL_EXPANDED_WIDE;
   endfunction : mode_special

   function automatic logic mode_single(input op_mode_e m);
      return m == MODE_NORMAL_SINGLE || m == MODE_SPECIAL_SINGLE;
   endfunction : mode_single

   function automatic logic mode_expanded(input op_mode_e m);
      return m == MODE_NORMAL_EXPANDED_NARROW || m == MODE_NORMAL_EXPANDED_WIDE ||
             m == MODE_SPECIAL_EXPANDED_NARROW || m == MODE_SPECIAL_EXPANDED_WIDE;
   endfunction : mode_expanded

   // Reset value of the assignment register for a mode.
   function automatic logic [7:0] assign_reset(input op_mode_e m);
      if (m == MODE_PERIPHERAL)
         return ASSIGN_RESET_PERIPHERAL;
      else if (m == MODE_NORMAL_SINGLE)
         return ASSIGN_RESET_NORMAL_SC;
      else if (mode_special(m))
         return ASSIGN_RESET_SPECIAL;
      else
         return ASSIGN_RESET_NORMAL_EXP;
   endfunction : assign_reset

   // Writes are allowed by a write-once / except-first policy.
   function automatic logic once_ok(input logic special, input logic written);
      return special ? written : !written;
   endfunction : once_ok

   logic [7:0]  pin_assign_reg;
   logic [7:0]  pin_assign_next;
   logic [7:0]  pull_up_reg;
   logic [7:0]  pull_up_next;
   logic [7:0]  low_drive_reg;
   logic [7:0]  low_drive_next;
   logic        assign_written_reg;
   logic        drive_written_reg;
   logic        loaded_reg;
   logic        wr_pend_reg;
   logic [7:0]  wr_index_reg;
   logic [31:0] hrdata_reg;

   wire         mode_spec  = mode_special(op_mode);
   wire         mode_sc    = mode_single(op_mode);
   wire         mode_exp   = mode_expanded(op_mode);
   wire         mode_per   = (op_mode == MODE_PERIPHERAL);
   wire         mode_nsc   = (op_mode == MODE_NORMAL_SINGLE);
   wire         mode_nexp  = (op_mode == MODE_NORMAL_EXPANDED_NARROW) || (op_mode == MODE_NORMAL_EXPANDED_WIDE);
   wire         mode_nnar  = (op_mode == MODE_NORMAL_EXPANDED_NARROW);

   wire         addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
   wire [7:0]   req_index  = {2'h0, haddr[7:2]};
   wire         word_ok    = (haddr[1:0] == 2'h0) && (hsize == HSIZE_WORD);
   wire         rd_take    = addr_phase && !hwrite && word_ok;
   wire         wr_take    = addr_phase && hwrite && word_ok;

   // Per-bit write permission masks for the assignment register.
   wire         once_a     = once_ok(mode_spec, assign_written_reg);
   wire         once_d     = once_ok(mode_spec, drive_written_reg);
   wire         no_external_eclk_ok   = mode_nsc ? !assign_written_reg : (op_mode == MODE_SPECIAL_SINGLE);
   wire         clock_test_enable_ok   = mode_spec && assign_written_reg;
   wire [7:0]   assign_wmask = {once_a, clock_test_enable_ok, once_a, no_external_eclk_ok, once_a, once_a, 1'b1, once_a};
   wire         assign_vis = !mode_per;
   wire         pad_vis    = !mode_per;

   wire         wr_assign  = wr_pend_reg && (wr_index_reg == PIN_ASSIGN_INDEX) && assign_vis;
   wire         wr_pull    = wr_pend_reg && (wr_index_reg == PULL_UP_INDEX) && pad_vis;
   wire         wr_drive   = wr_pend_reg && (wr_index_reg == LOW_DRIVE_INDEX) && pad_vis;

   assign pin_assign_next = wr_assign ?
                            ((hwdata[7:0] & assign_wmask) | (pin_assign_reg & ~assign_wmask)) : pin_assign_reg;
   assign pull_up_next    = wr_pull ? (hwdata[7:0] & PULL_UP_MASK) : pull_up_reg;
   assign low_drive_next  = (wr_drive && once_d) ? (hwdata[7:0] & LOW_DRIVE_MASK) : low_drive_reg;

   wire [31:0]  rd_value =
      (req_index == PIN_ASSIGN_INDEX && assign_vis) ? {24'h000000, pin_assign_reg} :
      (req_index == PULL_UP_INDEX && pad_vis)       ? {24'h000000, pull_up_reg} :
      (req_index == LOW_DRIVE_INDEX && pad_vis)     ? {24'h000000, low_drive_reg} :
      (req_index == STATUS_INDEX)                   ? {29'h00000000, drive_written_reg, assign_written_reg, loaded_reg} :
                                                      32'h00000000;

   // The assignment register loads its mode-dependent reset value on the first edge after reset.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         loaded_reg         <= 1'b0;
         pin_assign_reg     <= 8'h00;
         pull_up_reg        <= PULL_UP_RESET;
         low_drive_reg      <= LOW_DRIVE_RESET;
         assign_written_reg <= 1'b0;
         drive_written_reg  <= 1'b0;
      end
      else if (!loaded_reg)
      begin
         loaded_reg     <= 1'b1;
         pin_assign_reg <= assign_reset(op_mode);
      end
      else
      begin
         pin_assign_reg <= pin_assign_next;
         pull_up_reg    <= pull_up_next;
         low_drive_reg  <= low_drive_next;
         if (wr_assign)
            assign_written_reg <= 1'b1;
         if (wr_drive)
            drive_written_reg <= 1'b1;
      end
   end

   // Bus slave: zero wait states, reads registered at the address phase.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg  <= 1'b0;
         wr_index_reg <= 8'h00;
         hrdata_reg   <= 32'h00000000;
      end
      else
      begin
         wr_pend_reg  <= wr_take && loaded_reg;
         wr_index_reg <= req_index;
         if (rd_take)
            hrdata_reg <= rd_value;
      end
   end

   assign hrdata    = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Effective alternate functions.
   wire nde      = pin_assign_reg[NO_DATA_ENABLE_BIT];
   wire dbe_on   = mode_exp && !nde;
   wire cal_on   = !dbe_on && pin_assign_reg[CAL_REF_BIT];
   wire pipe_on  = mode_exp && pin_assign_reg[PIPE_STATUS_BIT];
   wire cgm_on   = !pipe_on && pin_assign_reg[CLOCK_TEST_BIT] && !mode_sc && !mode_nexp;
   wire eclk_on  = !pin_assign_reg[NO_EXT_ECLK_BIT] && !(mode_sc && bus_in.eclk_stretch_control);
   wire lstr_on  = pin_assign_reg[LOW_STROBE_BIT] && !mode_sc && !mode_nnar;
   wire rdw_on   = pin_assign_reg[READ_WRITE_BIT] && !mode_sc;
   wire pin7_val = !pin_assign_reg[DATA_ENABLE_SEL_BIT] ? bus_in.data_bus_enable : !bus_in.eclk;

   wire [7:0] alt_sel = {dbe_on || cal_on, pipe_on || cgm_on, pipe_on, eclk_on || mode_per,
                         lstr_on || mode_nnar, rdw_on, 2'b00};
   wire [7:0] alt_oe  = {dbe_on || cal_on, pipe_on || cgm_on, pipe_on, eclk_on && !mode_per,
                         lstr_on || mode_nnar, rdw_on, 2'b00};
   wire [7:0] alt_val = {dbe_on ? pin7_val : bus_in.calibration_reference,
                         pipe_on ? bus_in.queue_status_1 : bus_in.clock_generator_test,
                         bus_in.queue_status_0, bus_in.eclk,
                         lstr_on ? bus_in.low_byte_strobe : 1'b1, bus_in.read_write, 2'b00};
   wire [7:0] gpio_oe = bus_control_port_direction & 8'hFC;
   wire [7:0] drv_oe  = (alt_sel & alt_oe) | (~alt_sel & gpio_oe);
   wire [7:0] drv_val = (alt_sel & alt_val) | (~alt_sel & gpio_dout);

   assign pin_out.dout = drv_val;
   assign pin_out.oe_n = ~drv_oe;

   // Pull-ups on port E pins 7 and 3..0 only where the pin is an input.
   assign pull_enable = {8{pull_up_reg[PORT_E_BIT]}} & 8'h8F & ~drv_oe;
   assign port_a_pull_active = pull_up_reg[PORT_A_BIT] && !mode_exp && !mode_per;
   assign port_b_pull_active = pull_up_reg[PORT_B_BIT] && !mode_exp && !mode_per;
   assign port_g_pull_active = pull_up_reg[PORT_G_BIT];
   assign port_h_pull_active = pull_up_reg[PORT_H_BIT];
   assign low_drive = {low_drive_reg[PORT_H_BIT], low_drive_reg[PORT_G_BIT], low_drive_reg[PORT_E_BIT],
                       low_drive_reg[PORT_B_BIT], low_drive_reg[PORT_A_BIT]};
   // The tag is sampled by the debug logic at the falling E edge.
   assign low_byte_tag = lstr_on && mode_spec && mode_exp && !pin_in[3];

   alt_override_a : assert property (@(posedge hclk) disable iff (!hresetn)
      alt_sel[2] && rdw_on |-> !pin_out.oe_n[2] && pin_out.dout[2] == bus_in.read_write)
      else $error("read/write pin not driven");
   reset_value_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(loaded_reg) |-> pin_assign_reg == assign_reset($past(op_mode)))
      else $error("assignment reset value wrong");
   per_hidden_a : assert property (@(posedge hclk) disable iff (!hresetn)
      mode_per && rd_take && req_index == PIN_ASSIGN_INDEX |=> hrdata == 32'h00000000)
      else $error("register visible in peripheral mode");
   once_write_a : assert property (@(posedge hclk) disable iff (!hresetn)
      wr_assign && !mode_spec && assign_written_reg && !mode_nsc |=> $stable(pin_assign_reg[5:2]))
      else $error("write-once bit changed twice");
   cgm_never_a : assert property (@(posedge hclk) disable iff (!hresetn)
      loaded_reg && !mode_spec |=> $stable(pin_assign_reg[CLOCK_TEST_BIT]) || !$past(loaded_reg))
      else $error("clock test bit written in normal mode");
   pipe_prio_a : assert property (@(posedge hclk) disable iff (!hresetn)
      pipe_on |-> pin_out.dout[6] == bus_in.queue_status_1 && !pin_out.oe_n[5])
      else $error("pipe status not on pins");
   eclk_dir_a : assert property (@(posedge hclk) disable iff (!hresetn)
      mode_per |-> pin_out.oe_n[4])
      else $error("E clock driven in peripheral mode");
   narrow_high_a : assert property (@(posedge hclk) disable iff (!hresetn)
      mode_nnar |-> !pin_out.oe_n[3] && pin_out.dout[3])
      else $error("narrow strobe pin not high");
   cal_any_a : assert property (@(posedge hclk) disable iff (!hresetn)
      wr_assign |=> pin_assign_reg[CAL_REF_BIT] == $past(hwdata[CAL_REF_BIT]))
      else $error("calibration bit not written");
   pull_input_a : assert property (@(posedge hclk) disable iff (!hresetn)
      pull_enable[7] |-> pin_out.oe_n[7])
      else $error("pull on output pin");

   // Reset values of the assignment register, checked per mode group.
   nsc_reset_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(loaded_reg) && mode_nsc |-> pin_assign_reg == ASSIGN_RESET_NORMAL_SC)
      else $error("normal single-chip reset value wrong");

   nexp_reset_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(loaded_reg) && mode_nexp |-> pin_assign_reg == ASSIGN_RESET_NORMAL_EXP)
      else $error("normal expanded reset value wrong");

   spec_reset_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(loaded_reg) && mode_spec |-> pin_assign_reg == ASSIGN_RESET_SPECIAL)
      else $error("special reset value wrong");

   per_reset_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(loaded_reg) && mode_per |-> pin_assign_reg == ASSIGN_RESET_PERIPHERAL)
      else $error("peripheral reset value wrong");

   per_nowrite_a : assert property (@(posedge hclk) disable iff (!hresetn)
      mode_per && loaded_reg |=> $stable(pin_assign_reg))
      else $error("assignment changed in peripheral mode");

   // Write permissions of the assignment register.
   spec_first_a : assert property (@(posedge hclk) disable iff (!hresetn)
      wr_assign && mode_spec && !assign_written_reg |=> (pin_assign_reg & 8'hFD) == ($past(pin_assign_reg) & 8'hFD))
      else $error("first special write not ignored");

   normal_once_a : assert property (@(posedge hclk) disable iff (!hresetn)
      wr_assign && !mode_spec && !assign_written_reg |=> (pin_assign_reg & 8'hAD) == ($past(hwdata[7:0]) & 8'hAD))
      else $error("first normal write not taken");

   spec_later_a : assert property (@(posedge hclk) disable iff (!hresetn)
      wr_assign && mode_spec && assign_written_reg |=> (pin_assign_reg & 8'hEF) == ($past(hwdata[7:0]) & 8'hEF))
      else $error("later special write not taken");

   no_external_eclk_never_a : assert property (@(posedge hclk) disable iff (!hresetn)
      wr_assign && !mode_sc |=> $stable(pin_assign_reg[NO_EXT_ECLK_BIT]))
      else $error("no-eclk bit written outside single-chip");

   no_external_eclk_spec_a : assert property (@(posedge hclk) disable iff (!hresetn)
      wr_assign && op_mode == MODE_SPECIAL_SINGLE |=> pin_assign_reg[NO_EXT_ECLK_BIT] == $past(hwdata[NO_EXT_ECLK_BIT]))
      else $error("no-eclk bit not writable in special single-chip");

   // Pin 7 functions.
   dbe_pin_a : assert property (@(posedge hclk) disable iff (!hresetn)
      mode_exp && !nde && !pin_assign_reg[DATA_ENABLE_SEL_BIT]
      |-> !pin_out.oe_n[7] && pin_out.dout[7] == bus_in.data_bus_enable)
      else $error("data enable not on pin 7");

   inv_eclk_a : assert property (@(posedge hclk) disable iff (!hresetn)
      mode_exp && !nde && pin_assign_reg[DATA_ENABLE_SEL_BIT] |-> !pin_out.oe_n[7] && pin_out.dout[7] != bus_in.eclk)
      else $error("inverted E clock not on pin 7");

   cal_pin_a : assert property (@(posedge hclk) disable iff (!hresetn)
      (!mode_exp || nde) && pin_assign_reg[CAL_REF_BIT]
      |-> !pin_out.oe_n[7] && pin_out.dout[7] == bus_in.calibration_reference)
      else $error("calibration reference not on pin 7");

   // Pins 6 down to 2.
   cgm_pin_a : assert property (@(posedge hclk) disable iff (!hresetn)
      pin_assign_reg[CLOCK_TEST_BIT] && !pin_assign_reg[PIPE_STATUS_BIT] && !mode_sc && !mode_nexp
      |-> !pin_out.oe_n[6] && pin_out.dout[6] == bus_in.clock_generator_test)
      else $error("clock test not on pin 6");

   pipe_gpio_a : assert property (@(posedge hclk) disable iff (!hresetn)
      !(mode_exp && pin_assign_reg[PIPE_STATUS_BIT]) |-> pin_out.oe_n[5] == !bus_control_port_direction[5])
      else $error("pin 5 not general I/O");

   eclk_out_a : assert property (@(posedge hclk) disable iff (!hresetn)
      !mode_per && !pin_assign_reg[NO_EXT_ECLK_BIT] && !(mode_sc && bus_in.eclk_stretch_control)
      |-> !pin_out.oe_n[4] && pin_out.dout[4] == bus_in.eclk)
      else $error("E clock not on pin 4");

   eclk_gpio_a : assert property (@(posedge hclk) disable iff (!hresetn)
      pin_assign_reg[NO_EXT_ECLK_BIT] && !mode_per |-> pin_out.oe_n[4] == !bus_control_port_direction[4])
      else $error("pin 4 not general I/O");

   strobe_pin_a : assert property (@(posedge hclk) disable iff (!hresetn)
      pin_assign_reg[LOW_STROBE_BIT] && !mode_sc && !mode_nnar
      |-> !pin_out.oe_n[3] && pin_out.dout[3] == bus_in.low_byte_strobe)
      else $error("low strobe not on pin 3");

   strobe_gpio_a : assert property (@(posedge hclk) disable iff (!hresetn)
      mode_sc |-> pin_out.oe_n[3] == !bus_control_port_direction[3])
      else $error("pin 3 not general I/O in single-chip");

   rw_pin_a : assert property (@(posedge hclk) disable iff (!hresetn)
      pin_assign_reg[READ_WRITE_BIT] && !mode_sc |-> !pin_out.oe_n[2])
      else $error("read/write pin not output");

   rw_gpio_a : assert property (@(posedge hclk) disable iff (!hresetn)
      mode_sc |-> pin_out.oe_n[2] == !bus_control_port_direction[2])
      else $error("pin 2 not general I/O in single-chip");

   // Pad controls.
   pull_gpio_a : assert property (@(posedge hclk) disable iff (!hresetn)
      pull_up_reg[PORT_E_BIT] && pin_out.oe_n[0] |-> pull_enable[0])
      else $error("pull missing on input pin");

   pull_out_a : assert property (@(posedge hclk) disable iff (!hresetn)
      pull_enable[3] |-> pin_out.oe_n[3])
      else $error("pull on driven pin 3");

   bus_pull_a : assert property (@(posedge hclk) disable iff (!hresetn)
      mode_exp |-> !port_a_pull_active && !port_b_pull_active)
      else $error("bus port pull active");

   drive_once_a : assert property (@(posedge hclk) disable iff (!hresetn)
      wr_drive && !mode_spec && drive_written_reg |=> $stable(low_drive_reg))
      else $error("drive register written twice");

   drive_first_a : assert property (@(posedge hclk) disable iff (!hresetn)
      wr_drive && mode_spec && !drive_written_reg |=> $stable(low_drive_reg))
      else $error("first special drive write taken");

   pad_hidden_a : assert property (@(posedge hclk) disable iff (!hresetn)
      mode_per && loaded_reg |=> $stable(pull_up_reg) && $stable(low_drive_reg))
      else $error("pad register changed in peripheral mode");

   pad_read_a : assert property (@(posedge hclk) disable iff (!hresetn)
      mode_per && rd_take && req_index != STATUS_INDEX |=> hrdata == 32'h00000000)
      else $error("pad register visible in peripheral mode");

   // The write flags only ever rise until the next reset.
   flag_keep_a : assert property (@(posedge hclk) disable iff (!hresetn)
      assign_written_reg |=> assign_written_reg)
      else $error("assignment write flag cleared");

   flag_set_a : assert property (@(posedge hclk) disable iff (!hresetn)
      wr_assign |=> assign_written_reg)
      else $error("assignment write flag not set");

   drive_flag_a : assert property (@(posedge hclk) disable iff (!hresetn)
      wr_drive |=> drive_written_reg)
      else $error("drive write flag not set");

endmodule : bus_control_pin_mux

// *** tb/bus_partner.sv ***
module bus_partner
(
   // Clock for the floating-line pattern.
   input  wire logic                     hclk,
   // Device side of the port pins.
   input  wire port_ctl_pkg::pin_drive_s pin_out,
   input  wire logic [7:0]               pull_enable,
   // Request to tag the low byte.
   input  wire logic                     tag_low,
   // Resolved pin levels.
   output logic [7:0]                    pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import port_ctl_pkg::*;

   logic [7:0] float_pat = 8'h55;

   always @(posedge hclk)
      float_pat <= ~float_pat;

   // A released line floats with a changing pattern unless a pull holds it high.
   always_comb
      for (int i = 0; i < 8; i++)
         if (i == 3 && tag_low)
            pin_in[i] = 1'b0;
         else if (!pin_out.oe_n[i])
            pin_in[i] = pin_out.dout[i];
         else
            pin_in[i] = pull_enable[i] | float_pat[i];
endmodule : bus_partner

// *** tb/testbench.sv ***
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import port_ctl_pkg::*;

   localparam logic [31:0] PA = {22'h0, PIN_ASSIGN_INDEX, 2'b00};
   localparam logic [31:0] PU = {22'h0, PULL_UP_INDEX, 2'b00};
   localparam logic [31:0] LD = {22'h0, LOW_DRIVE_INDEX, 2'b00};

   logic         hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, tag_low;
   logic [31:0]  haddr, hwdata, hrdata, rdata;
   logic [1:0]   htrans;
   logic [2:0]   hsize;
   op_mode_e     op_mode;
   bus_signals_s bus_in;
   pin_drive_s   pin_out;
   logic [7:0]   gpio_dout, dir, pin_in, pull_enable;
   logic [4:0]   low_drive;
   logic         pa, pb, pg, ph, low_byte_tag;
   int           err_total, n_tests;
   logic [7:0]   ev [7] = '{8'h90, 8'h2C, 8'h00, 8'h00, 8'h2C, 8'h2C, 8'h00};

   assign hready = hreadyout;

   bus_control_pin_mux bus_control_pin_mux_i
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .op_mode(op_mode), .bus_in(bus_in),
      .gpio_dout(gpio_dout), .bus_control_port_direction(dir), .pin_in(pin_in),
      .pin_out(pin_out), .pull_enable(pull_enable), .port_a_pull_active(pa),
      .port_b_pull_active(pb), .port_g_pull_active(pg), .port_h_pull_active(ph),
      .low_drive(low_drive), .low_byte_tag(low_byte_tag)
   );

   bus_partner bus_partner_i
   (
      .hclk(hclk), .pin_out(pin_out), .pull_enable(pull_enable), .tag_low(tag_low), .pin_in(pin_in)
   );

   task end_sim;
      if (err_total == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   // Pin levels are compared only where the pin is expected to be driven.
   task cp(input logic [7:0] m, input logic [7:0] d, input logic [7:0] oe);
      #1;
      chk(pin_out.oe_n & m, oe);
      chk(pin_out.dout & m & ~oe, d);
      @(posedge hclk);
   endtask : cp

   task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= HSIZE_WORD;
      @(posedge hclk);
      while (hready !== 1'b1)
         @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1)
         @(posedge hclk);
      rdata = hrdata;
   endtask : xfer

   task wr(input logic [31:0] a, input logic [7:0] d);
      xfer(a, 1'b1, {24'h0, d});
   endtask : wr

   task rd(input logic [31:0] a, input logic [7:0] e);
      xfer(a, 1'b0, 32'h0);
      chk(rdata, {24'h0, e});
   endtask : rd

   task rst(input op_mode_e m);
      hresetn <= 1'b0;
      op_mode <= m;
      bus_in <= 9'h117;
      dir <= 8'h00;
      gpio_dout <= 8'h00;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
   endtask : rst

   initial
   begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   initial
   begin
      #20000;
      err_total++;
      end_sim;
   end

   initial
   begin
      hresetn <= 1'b0;
      hsel <= 1'b0;
      haddr <= 32'h0;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hsize <= HSIZE_WORD;
      hwdata <= 32'h0;
      tag_low <= 1'b0;
      for (int i = 0; i < 7; i++)
      begin
         rst(op_mode_e'(i));
         rd(PA, ev[i]);
         rd(PU, 8'h00);
         rd(LD, 8'h00);
      end
      rd(32'h3C, 8'h00);
      rst(MODE_NORMAL_EXPANDED_WIDE);
      cp(8'h94, 8'h10, 8'h04);
      wr(PA, 8'h2D);
      cp(8'hFC, 8'h34, 8'h00);
      dir <= 8'hFF;
      gpio_dout <= 8'hFF;
      cp(8'hFC, 8'h34, 8'h00);
      wr(PA, 8'hFF);
      rd(PA, 8'h2F);
      wr(PU, 8'h73);
      rd(PU, 8'h73);
      chk({pa, pb, pg, ph}, 4'h3);
      rst(MODE_NORMAL_SINGLE);
      cp(8'h10, 8'h00, 8'h10);
      wr(PU, 8'h13);
      @(posedge hclk);
      chk(pull_enable, 8'h8F);
      chk({pa, pb}, 2'h3);
      wr(PA, 8'h06);
      rd(PA, 8'h06);
      cp(8'h94, 8'h90, 8'h04);
      bus_in <= 9'h197;
      cp(8'h10, 8'h00, 8'h10);
      wr(PA, 8'h00);
      rd(PA, 8'h04);
      wr(LD, 8'h13);
      wr(LD, 8'h60);
      rd(LD, 8'h13);
      chk(low_drive, 5'h07);
      rst(MODE_SPECIAL_EXPANDED_WIDE);
      bus_in <= 9'h11F;
      cp(8'h08, 8'h08, 8'h00);
      chk(low_byte_tag, 1'b0);
      tag_low <= 1'b1;
      @(posedge hclk);
      chk(low_byte_tag, 1'b1);
      tag_low <= 1'b0;
      wr(PA, 8'hC3);
      rd(PA, 8'h2E);
      wr(PA, 8'h50);
      rd(PA, 8'h40);
      cp(8'h40, 8'h40, 8'h00);
      wr(PA, 8'h60);
      cp(8'h40, 8'h00, 8'h00);
      wr(LD, 8'h13);
      rd(LD, 8'h00);
      wr(LD, 8'h13);
      rd(LD, 8'h13);
      rst(MODE_PERIPHERAL);
      wr(PA, 8'hFF);
      rd(PA, 8'h00);
      cp(8'h50, 8'h40, 8'h10);
      wr(PU, 8'h73);
      rd(PU, 8'h00);
      rst(MODE_NORMAL_EXPANDED_NARROW);
      cp(8'h08, 8'h08, 8'h00);
      wr(PA, 8'h08);
      cp(8'h08, 8'h08, 8'h00);
      end_sim;
   end
endmodule : testbench
